// ==== hw/smpc_top.sv ====
// stop-mode power controller with low-voltage register file and APB slave
module smpc_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire smpc_pkg::smpc_apb_req_t I_APB,
  output smpc_pkg::smpc_apb_rsp_t O_APB,
  input wire logic I_STOP_EXEC,
  input wire logic I_DEBUG_ENTRY_ALLOW,
  input wire logic I_RESET_PIN_N,
  input wire logic I_EXT_IRQ_N,
  input wire logic I_WAKE_IRQ,
  input wire logic I_DEBUG_HALT_CMD,
  input wire logic I_DBG_MEM_REQ,
  input wire logic I_LV_LOW,
  input wire logic I_VDD_ABOVE_REARM,
  input wire logic I_XTAL_RUN_IN_STOP,
  input wire logic I_CONVERTER_POWER_UP,
  input wire logic I_WAKE_TIMER_EN,
  output smpc_pkg::smpc_mode_t O_STOP_MODE,
  output smpc_pkg::smpc_pwr_t O_PWR,
  output logic O_ILLEGAL_OP_RST,
  output logic O_POR_SEQ,
  output logic O_BGND_ENTER,
  output logic O_LV_IRQ,
  output logic O_LV_RESET,
  output logic O_LV_IND,
  output logic O_DBG_MEM_GO,
  output logic O_DBG_MEM_ERR,
  output logic O_DBG_IN_STOP,
  output logic O_DBG_ALL_CMDS
);
  import smpc_pkg::*;

  smpc_mode_t mode_q, mode_d;
  logic lv_on_q, lv_in_stop_q, lv_irq_on_q, lv_rst_on_q, lv_flag_q;
  logic pdc_q, partial_power_down_ctl_q, stop_allow_q;
  logic dbg_stop_q, lv_stop_q;
  logic lv_ind_q, pin_latch_q;
  logic illegal_q, por_q, bgnd_q;
  logic dbg_go_q, dbg_err_q;
  logic [APB_DW-1:0] prdata_q;
  smpc_pwr_t pwr_q, pwr_d;

  logic apb_setup, apb_wr, addr_hit;
  logic wr_lv, wr_pm;
  logic stop_req, stop_bad, force3;
  logic wake1, wake2, wake3, halt_wake;
  logic lv_event;
  smpc_mode_t sel_mode;

  // elaboration checks: the register fields must fit the bus word and the low byte
  if (APB_DW < 8) begin : g_chk_width
    $error("register bus narrower than the register fields");
  end

  if ((OFF_LV_POWER_CTL1[1:0] != 2'h0) || (OFF_POWER_MGMT_CTL2[1:0] != 2'h0) ||
      (OFF_STOP_STATUS[1:0] != 2'h0)) begin : g_chk_align
    $error("register offsets must be word aligned");
  end

  if ((OFF_LV_POWER_CTL1 == OFF_POWER_MGMT_CTL2) || (OFF_LV_POWER_CTL1 == OFF_STOP_STATUS) ||
      (OFF_POWER_MGMT_CTL2 == OFF_STOP_STATUS)) begin : g_chk_unique
    $error("register offsets must differ");
  end

  if ((STAT_DBG_STOP_BIT > 7) || (LV_FLAG_BIT > 7) || (PIN_RELEASE_BIT > 7)) begin : g_chk_field
    $error("register field outside the low byte");
  end

  if (STAT_MODE_LSB + 2 > STAT_PIN_LATCH_BIT) begin : g_chk_stat
    $error("status mode field overlaps the pin latch bit");
  end

  // apb slave: zero wait states, error on unmapped addresses
  assign apb_setup = I_APB.psel && !I_APB.penable;
  assign apb_wr = I_APB.psel && I_APB.penable && I_APB.pwrite;
  assign addr_hit = (I_APB.paddr == OFF_LV_POWER_CTL1) ||
                    (I_APB.paddr == OFF_POWER_MGMT_CTL2) ||
                    (I_APB.paddr == OFF_STOP_STATUS);
  assign wr_lv = apb_wr && (I_APB.paddr == OFF_LV_POWER_CTL1);
  assign wr_pm = apb_wr && (I_APB.paddr == OFF_POWER_MGMT_CTL2);

  assign O_APB.pready = 1'b1;
  assign O_APB.pslverr = I_APB.psel && I_APB.penable && !addr_hit;
  assign O_APB.prdata = prdata_q;

  // read data is captured in the setup cycle so it comes from a flop in the access cycle
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      prdata_q <= '0;
    end else if (apb_setup) begin
      prdata_q <= '0;
      case (I_APB.paddr)
        OFF_LV_POWER_CTL1: begin
          prdata_q[LV_FLAG_BIT] <= lv_flag_q;
          prdata_q[LV_CLEAR_BIT] <= 1'b0;
          prdata_q[LV_IRQ_ON_BIT] <= lv_irq_on_q;
          prdata_q[LV_RESET_ON_BIT] <= lv_rst_on_q;
          prdata_q[LV_IN_STOP_BIT] <= lv_in_stop_q;
          prdata_q[LV_ON_BIT] <= lv_on_q;
        end
        OFF_POWER_MGMT_CTL2: begin
          prdata_q[PDC_BIT] <= pdc_q;
          prdata_q[PARTIAL_POWER_DOWN_CTL_BIT] <= partial_power_down_ctl_q;
          prdata_q[STOP_ALLOW_BIT] <= stop_allow_q;
        end
        OFF_STOP_STATUS: begin
          prdata_q[STAT_MODE_LSB +: 2] <= mode_q;
          prdata_q[STAT_PIN_LATCH_BIT] <= pin_latch_q;
          prdata_q[STAT_LV_IND_BIT] <= lv_ind_q;
          prdata_q[STAT_DBG_STOP_BIT] <= dbg_stop_q;
        end
        default: begin
          prdata_q <= '0;
        end
      endcase
    end
  end

  // low-voltage control bits; a stop1 wake clears them as a power-on would
  // mode and the stop1 indication are not cleared by it, so the wake is not undone
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || por_q) begin
      lv_on_q <= LV_POWER_CTL1_RST[LV_ON_BIT];
      lv_in_stop_q <= LV_POWER_CTL1_RST[LV_IN_STOP_BIT];
      lv_irq_on_q <= LV_POWER_CTL1_RST[LV_IRQ_ON_BIT];
      lv_rst_on_q <= LV_POWER_CTL1_RST[LV_RESET_ON_BIT];
    end else if (wr_lv) begin
      lv_on_q <= I_APB.pwdata[LV_ON_BIT];
      lv_in_stop_q <= I_APB.pwdata[LV_IN_STOP_BIT];
      lv_irq_on_q <= I_APB.pwdata[LV_IRQ_ON_BIT];
      lv_rst_on_q <= I_APB.pwdata[LV_RESET_ON_BIT];
    end
  end

  // detection runs in stop only when enabled for stop
  assign lv_event = lv_on_q && I_LV_LOW && ((mode_q == SMPC_RUN) || lv_stop_q);

  // an event in the clear cycle keeps the flag set
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || por_q) begin
      lv_flag_q <= LV_POWER_CTL1_RST[LV_FLAG_BIT];
    end else if (lv_event) begin
      lv_flag_q <= 1'b1;
    end else if (wr_lv && I_APB.pwdata[LV_CLEAR_BIT]) begin
      lv_flag_q <= 1'b0;
    end
  end

  assign O_LV_IRQ = lv_flag_q && lv_irq_on_q;
  assign O_LV_RESET = lv_flag_q && lv_rst_on_q && lv_on_q;

  // power mode control bits
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || por_q) begin
      pdc_q <= POWER_MGMT_CTL2_RST[PDC_BIT];
      partial_power_down_ctl_q <= POWER_MGMT_CTL2_RST[PARTIAL_POWER_DOWN_CTL_BIT];
      stop_allow_q <= POWER_MGMT_CTL2_RST[STOP_ALLOW_BIT];
    end else if (wr_pm) begin
      pdc_q <= I_APB.pwdata[PDC_BIT];
      partial_power_down_ctl_q <= I_APB.pwdata[PARTIAL_POWER_DOWN_CTL_BIT];
      stop_allow_q <= I_APB.pwdata[STOP_ALLOW_BIT];
    end
  end

  // stop entry decision, all inputs taken in the STOP cycle
  // a STOP while already stopped is not decoded: only RUN looks at it
  // debug wins over low-voltage forcing when both qualify, see the power table below
  assign stop_req = I_STOP_EXEC && (mode_q == SMPC_RUN);
  assign stop_bad = stop_req && !stop_allow_q;
  assign force3 = I_DEBUG_ENTRY_ALLOW || (lv_on_q && lv_in_stop_q);

  always_comb begin
    if (!pdc_q || force3) begin
      sel_mode = SMPC_STOP3;
    end else if (partial_power_down_ctl_q) begin
      sel_mode = SMPC_STOP2;
    end else begin
      sel_mode = SMPC_STOP1;
    end
  end

  // stop1 wake is held off while the low-voltage indication stands
  assign wake1 = (!I_RESET_PIN_N || !I_EXT_IRQ_N) && !lv_ind_q;
  assign wake2 = !I_RESET_PIN_N || I_WAKE_IRQ;
  assign halt_wake = dbg_stop_q && I_DEBUG_HALT_CMD;
  assign wake3 = !I_RESET_PIN_N || I_WAKE_IRQ || halt_wake;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SMPC_RUN: begin
        if (stop_req && stop_allow_q) begin
          mode_d = sel_mode;
        end
      end
      SMPC_STOP1: begin
        if (wake1) begin
          mode_d = SMPC_RUN;
        end
      end
      SMPC_STOP2: begin
        if (wake2) begin
          mode_d = SMPC_RUN;
        end
      end
      SMPC_STOP3: begin
        if (wake3) begin
          mode_d = SMPC_RUN;
        end
      end
      default: begin
        mode_d = SMPC_RUN;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mode_q <= SMPC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // stop qualifiers latched at entry so later register changes cannot alter the stop
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      dbg_stop_q <= 1'b0;
      lv_stop_q <= 1'b0;
    end else if (stop_req && stop_allow_q) begin
      dbg_stop_q <= I_DEBUG_ENTRY_ALLOW;
      lv_stop_q <= lv_on_q && lv_in_stop_q;
    end else if (mode_q == SMPC_RUN) begin
      dbg_stop_q <= 1'b0;
      lv_stop_q <= 1'b0;
    end
  end

  // low-voltage indication forced on stop1 entry, dropped once supply passes rearm
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      lv_ind_q <= 1'b0;
    end else if (stop_req && stop_allow_q && (sel_mode == SMPC_STOP1)) begin
      lv_ind_q <= 1'b1;
    end else if (I_VDD_ABOVE_REARM) begin
      lv_ind_q <= 1'b0;
    end
  end

  assign O_LV_IND = lv_ind_q;

  // stop2 pin latches stay closed after wake until software releases them,
  // giving it time to restore port registers saved in RAM
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || por_q) begin
      pin_latch_q <= 1'b0;
    end else if (stop_req && stop_allow_q && (sel_mode == SMPC_STOP2)) begin
      pin_latch_q <= 1'b1;
    end else if (wr_pm && I_APB.pwdata[PIN_RELEASE_BIT]) begin
      pin_latch_q <= 1'b0;
    end
  end

  // one-cycle event pulses
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      illegal_q <= 1'b0;
      por_q <= 1'b0;
      bgnd_q <= 1'b0;
    end else begin
      illegal_q <= stop_bad;
      por_q <= (mode_q == SMPC_STOP1) && wake1;
      bgnd_q <= (mode_q == SMPC_STOP3) && halt_wake;
    end
  end

  assign O_ILLEGAL_OP_RST = illegal_q;
  assign O_POR_SEQ = por_q;
  assign O_BGND_ENTER = bgnd_q;

  // memory-with-status debug commands: access only while running
  // the error pulse tells the host the core is stopped; only in a debug-entered stop3 can it halt and retry
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      dbg_go_q <= 1'b0;
      dbg_err_q <= 1'b0;
    end else begin
      dbg_go_q <= I_DBG_MEM_REQ && (mode_q == SMPC_RUN);
      dbg_err_q <= I_DBG_MEM_REQ && (mode_q != SMPC_RUN);
    end
  end

  assign O_DBG_MEM_GO = dbg_go_q;
  assign O_DBG_MEM_ERR = dbg_err_q;
  assign O_DBG_IN_STOP = (mode_q != SMPC_RUN);
  assign O_DBG_ALL_CMDS = (mode_q == SMPC_RUN);
  assign O_STOP_MODE = mode_q;

  // power domain controls per mode
  always_comb begin
    pwr_d = '0;
    pwr_d.core = SMPC_DOM_ACTIVE;
    pwr_d.ram = SMPC_DOM_ACTIVE;
    pwr_d.clkgen = SMPC_DOM_ACTIVE;
    pwr_d.regulator = SMPC_DOM_ACTIVE;
    pwr_d.periph_clk_en = 1'b1;
    pwr_d.debug_clk_en = 1'b1;
    pwr_d.adc_enable = 1'b1;
    pwr_d.adc_power_down = 1'b0;
    pwr_d.io_reset = 1'b0;
    pwr_d.io_hold = pin_latch_q;
    pwr_d.wake_timer_allow = 1'b1;
    pwr_d.wake_timer_1k_ok = 1'b1;
    if (mode_d != SMPC_RUN) begin
      pwr_d.periph_clk_en = 1'b0;
      pwr_d.adc_enable = 1'b0;
      pwr_d.adc_power_down = !I_CONVERTER_POWER_UP;
      pwr_d.wake_timer_allow = I_WAKE_TIMER_EN;
    end
    case (mode_d)
      SMPC_STOP1: begin
        pwr_d.core = SMPC_DOM_OFF;
        pwr_d.ram = SMPC_DOM_OFF;
        pwr_d.clkgen = SMPC_DOM_OFF;
        pwr_d.regulator = SMPC_DOM_STANDBY;
        pwr_d.debug_clk_en = 1'b0;
        pwr_d.io_reset = 1'b1;
        pwr_d.io_hold = 1'b0;
        pwr_d.wake_timer_allow = 1'b0;
      end
      SMPC_STOP2: begin
        pwr_d.core = SMPC_DOM_OFF;
        pwr_d.ram = SMPC_DOM_STANDBY;
        pwr_d.clkgen = SMPC_DOM_OFF;
        pwr_d.regulator = SMPC_DOM_STANDBY;
        pwr_d.debug_clk_en = 1'b0;
        pwr_d.io_hold = 1'b1;
      end
      SMPC_STOP3: begin
        pwr_d.core = SMPC_DOM_STANDBY;
        pwr_d.ram = SMPC_DOM_STANDBY;
        pwr_d.io_hold = 1'b1;
        pwr_d.clkgen = I_XTAL_RUN_IN_STOP ? SMPC_DOM_ACTIVE : SMPC_DOM_OFF;
        pwr_d.regulator = SMPC_DOM_STANDBY;
        pwr_d.debug_clk_en = 1'b0;
        if (lv_stop_q || (stop_req && force3 && !I_DEBUG_ENTRY_ALLOW)) begin
          pwr_d.regulator = SMPC_DOM_ACTIVE;
          pwr_d.clkgen = SMPC_DOM_STANDBY;
        end
        if (dbg_stop_q || (stop_req && I_DEBUG_ENTRY_ALLOW)) begin
          pwr_d.debug_clk_en = 1'b1;
          pwr_d.regulator = SMPC_DOM_ACTIVE;
          pwr_d.clkgen = SMPC_DOM_ACTIVE;
          pwr_d.wake_timer_1k_ok = 1'b0;
        end
      end
      default: begin
        pwr_d.core = SMPC_DOM_ACTIVE;
      end
    endcase
  end

  // registered from the next mode, so the domain controls switch glitch-free at the mode edge
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pwr_q <= '{core: SMPC_DOM_ACTIVE, ram: SMPC_DOM_ACTIVE, clkgen: SMPC_DOM_ACTIVE,
                 regulator: SMPC_DOM_ACTIVE, periph_clk_en: 1'b1, debug_clk_en: 1'b1,
                 adc_enable: 1'b1, adc_power_down: 1'b0, io_reset: 1'b0, io_hold: 1'b0,
                 wake_timer_allow: 1'b1, wake_timer_1k_ok: 1'b1};
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign O_PWR = pwr_q;

endmodule // smpc_top

// ==== hw/smpc_pkg.sv ====
// constants, types and register layout of the stop-mode power controller
package smpc_pkg;

  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register byte addresses
  localparam logic [APB_AW-1:0] OFF_LV_POWER_CTL1 = 8'h00;
  localparam logic [APB_AW-1:0] OFF_POWER_MGMT_CTL2 = 8'h04;
  localparam logic [APB_AW-1:0] OFF_STOP_STATUS = 8'h08;

  // low_voltage_power_ctl1 fields
  localparam int LV_FLAG_BIT = 7;
  localparam int LV_CLEAR_BIT = 6;
  localparam int LV_IRQ_ON_BIT = 5;
  localparam int LV_RESET_ON_BIT = 4;
  localparam int LV_IN_STOP_BIT = 3;
  localparam int LV_ON_BIT = 2;
  localparam logic [7:0] LV_POWER_CTL1_RST = 8'h00;

  // power_mgmt_ctl2 fields
  localparam int PDC_BIT = 0;
  localparam int PARTIAL_POWER_DOWN_CTL_BIT = 1;
  localparam int STOP_ALLOW_BIT = 2;
  localparam int PIN_RELEASE_BIT = 3;
  localparam logic [3:0] POWER_MGMT_CTL2_RST = 4'h0;

  // stop_status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PIN_LATCH_BIT = 2;
  localparam int STAT_LV_IND_BIT = 3;
  localparam int STAT_DBG_STOP_BIT = 4;

  typedef enum logic [1:0] {
    SMPC_RUN = 2'h0,
    SMPC_STOP3 = 2'h1,
    SMPC_STOP2 = 2'h3,
    SMPC_STOP1 = 2'h2
  } smpc_mode_t;

  typedef enum logic [1:0] {
    SMPC_DOM_OFF = 2'h0,
    SMPC_DOM_STANDBY = 2'h1,
    SMPC_DOM_ACTIVE = 2'h2
  } smpc_dom_t;

  typedef struct packed {
    smpc_dom_t core;
    smpc_dom_t ram;
    smpc_dom_t clkgen;
    smpc_dom_t regulator;
    logic periph_clk_en;
    logic debug_clk_en;
    logic adc_enable;
    logic adc_power_down;
    logic io_reset;
    logic io_hold;
    logic wake_timer_allow;
    logic wake_timer_1k_ok;
  } smpc_pwr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } smpc_apb_req_t;

  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } smpc_apb_rsp_t;

endpackage

// ==== test/smpc_chk_monitor.sv ====
// port-level assertions for the stop-mode power controller
module smpc_monitor
  import smpc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_STOP_EXEC,
  input wire logic I_DEBUG_ENTRY_ALLOW,
  input wire logic I_RESET_PIN_N,
  input wire logic I_EXT_IRQ_N,
  input wire logic I_DBG_MEM_REQ,
  input wire smpc_pkg::smpc_mode_t O_STOP_MODE,
  input wire smpc_pkg::smpc_pwr_t O_PWR,
  input wire logic O_ILLEGAL_OP_RST,
  input wire logic O_POR_SEQ,
  input wire logic O_BGND_ENTER,
  input wire logic O_LV_IND,
  input wire logic O_DBG_MEM_GO,
  input wire logic O_DBG_MEM_ERR,
  input wire logic O_DBG_ALL_CMDS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  chk_illegal_op: assert property (
    O_ILLEGAL_OP_RST |-> $past(I_STOP_EXEC) && O_STOP_MODE == SMPC_RUN)
    else $error("illegal opcode reset without stop or with mode change");
  chk_dbg_force: assert property (
    I_STOP_EXEC && I_DEBUG_ENTRY_ALLOW && O_STOP_MODE == SMPC_RUN
    |=> O_STOP_MODE inside {SMPC_RUN, SMPC_STOP3}) else $error("debug stop not stop3");
  chk_dbg_power: assert property (
    (I_STOP_EXEC && I_DEBUG_ENTRY_ALLOW && O_STOP_MODE == SMPC_RUN) ##1
    (O_STOP_MODE != SMPC_RUN) |=> O_PWR.debug_clk_en && O_PWR.regulator == SMPC_DOM_ACTIVE
    && O_PWR.clkgen == SMPC_DOM_ACTIVE) else $error("debug stop power wrong");
  chk_periph_off: assert property (
    O_STOP_MODE != SMPC_RUN && $past(O_STOP_MODE) != SMPC_RUN |-> !O_PWR.periph_clk_en)
    else $error("peripheral clock running in stop");
  chk_stop1_off: assert property (
    O_STOP_MODE == SMPC_STOP1 && $past(O_STOP_MODE) == SMPC_STOP1
    |-> O_PWR.io_reset && O_PWR.ram == SMPC_DOM_OFF) else $error("stop1 power wrong");
  chk_stop2_hold: assert property (
    O_STOP_MODE == SMPC_STOP2 && $past(O_STOP_MODE) == SMPC_STOP2
    |-> O_PWR.io_hold && O_PWR.ram == SMPC_DOM_STANDBY) else $error("stop2 power wrong");
  chk_stop1_pins: assert property (
    O_STOP_MODE == SMPC_STOP1 && I_RESET_PIN_N && I_EXT_IRQ_N
    |=> O_STOP_MODE == SMPC_STOP1) else $error("stop1 left without wake pin");
  chk_stop1_lvhold: assert property (
    O_STOP_MODE == SMPC_STOP1 && O_LV_IND |=> O_STOP_MODE == SMPC_STOP1)
    else $error("stop1 left below rearm level");
  chk_stop1_por: assert property (
    O_STOP_MODE == SMPC_STOP1 ##1 O_STOP_MODE == SMPC_RUN |-> O_POR_SEQ)
    else $error("stop1 wake without power-on sequence");
  chk_mem_err: assert property (
    I_DBG_MEM_REQ && O_STOP_MODE != SMPC_RUN |=> O_DBG_MEM_ERR && !O_DBG_MEM_GO)
    else $error("memory command in stop not refused");
  chk_bgnd_wake: assert property (
    O_BGND_ENTER |-> O_STOP_MODE == SMPC_RUN && $past(O_STOP_MODE) == SMPC_STOP3
    && O_DBG_ALL_CMDS) else $error("background entry wrong");
endmodule // smpc_monitor

bind smpc_top smpc_monitor smpc_mon_u (.*);

// ==== test/smpc_pin_model.sv ====
// wake pins and debug host facing the stop controller
module smpc_pin_model (
  input wire logic i_clk,
  input wire logic [2:0] i_cmd,
  output logic o_rst_pin_n,
  output logic o_irq_pin_n,
  output logic o_wake_irq,
  output logic o_halt,
  output logic o_mem_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cmd_q = 3'h0;
  always @(posedge i_clk) cmd_q <= i_cmd;
  // pins rest inactive; codes 1 to 5 each assert one line, one cycle late, for as long as the code is held
  assign o_rst_pin_n = cmd_q != 3'h1;
  assign o_irq_pin_n = cmd_q != 3'h2;
  assign o_wake_irq = cmd_q == 3'h3;
  assign o_halt = cmd_q == 3'h4;
  assign o_mem_req = cmd_q == 3'h5;
endmodule // smpc_pin_model

// ==== test/tb.sv ====
// self-checking bench for the stop-mode power controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smpc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  smpc_apb_req_t apb = '0;
  smpc_apb_rsp_t rsp;
  logic stp = 1'b0, dbg = 1'b0, lv_low = 1'b0, vdd_ok = 1'b0, cpu_up = 1'b0;
  logic xtal = 1'b0, wte = 1'b1;
  logic [2:0] cmd = 3'h0;
  logic rpn, ipn, wirq, halt, mreq, ill, por, bg, lvirq, lvrst, lvind, go, err, allc, ins;
  smpc_mode_t mode;
  smpc_pwr_t pwr;
  int errors = 0, checks = 0, n_ill = 0, n_por = 0, n_bg = 0, n_go = 0, n_err = 0;
  always #2 clk = ~clk;
  smpc_pin_model pins_u (.i_clk(clk), .i_cmd(cmd), .o_rst_pin_n(rpn), .o_irq_pin_n(ipn),
    .o_wake_irq(wirq), .o_halt(halt), .o_mem_req(mreq));
  smpc_top dut_u (.I_REF_CLK(clk), .I_RST(rst), .I_APB(apb), .O_APB(rsp), .I_STOP_EXEC(stp),
    .I_DEBUG_ENTRY_ALLOW(dbg), .I_RESET_PIN_N(rpn), .I_EXT_IRQ_N(ipn), .I_WAKE_IRQ(wirq),
    .I_DEBUG_HALT_CMD(halt), .I_DBG_MEM_REQ(mreq), .I_LV_LOW(lv_low),
    .I_VDD_ABOVE_REARM(vdd_ok), .I_XTAL_RUN_IN_STOP(xtal), .I_CONVERTER_POWER_UP(cpu_up),
    .I_WAKE_TIMER_EN(wte), .O_STOP_MODE(mode), .O_PWR(pwr), .O_ILLEGAL_OP_RST(ill),
    .O_POR_SEQ(por), .O_BGND_ENTER(bg), .O_LV_IRQ(lvirq), .O_LV_RESET(lvrst), .O_LV_IND(lvind),
    .O_DBG_MEM_GO(go), .O_DBG_MEM_ERR(err), .O_DBG_IN_STOP(ins), .O_DBG_ALL_CMDS(allc));
  // one-cycle pulses are tallied so tasks can judge them after the fact
  always @(posedge clk) begin
    n_ill += (ill === 1'b1);
    n_por += (por === 1'b1);
    n_bg += (bg === 1'b1);
    n_go += (go === 1'b1);
    n_err += (err === 1'b1);
  end
  task automatic end_sim;
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    q = rsp.prdata;
    e = rsp.pslverr;
    apb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    cmp(n, x, q);
  endtask
  task automatic pin(input logic [2:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
    cyc(3);
  endtask
  task automatic enter(input logic [7:0] ctl2, input logic [31:0] x);
    wr(8'h04, {24'h0, ctl2});
    @(posedge clk);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    cyc(3);
    cmp("mode", x, mode);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd("ctl1 reset", 8'h00, 32'h0);
    rd("ctl2 reset", 8'h04, 32'h0);
    xfer(1'b0, 8'h40, 32'h0, q, e);
    cmp("unmapped err", 32'h1, {31'h0, e});
    wr(8'h00, 32'hFF);
    rd("ctl1 rw", 8'h00, 32'h3C);
    wr(8'h00, 32'h20);
    lv_low <= 1'b1;
    cyc(2);
    rd("flag detector off", 8'h00, 32'h20);
    wr(8'h00, 32'h34);
    cyc(2);
    rd("flag set", 8'h00, 32'hB4);
    cmp("irq rst", 32'h3, {lvirq, lvrst});
    wr(8'h00, 32'h30);
    cyc(1);
    cmp("rst needs detector", 32'h2, {lvirq, lvrst});
    lv_low <= 1'b0;
    wr(8'h00, 32'h74);
    rd("flag cleared", 8'h00, 32'h34);
    cmp("irq off", 32'h0, lvirq);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_illegal;
    enter(8'h00, SMPC_RUN);
    cmp("illegal pulses", 32'h1, n_ill);
  endtask
  task automatic t_stop1;
    enter(8'h05, SMPC_STOP1);
    cmp("stop1 pwr", {SMPC_DOM_OFF, SMPC_DOM_OFF, 2'b10},
        {pwr.ram, pwr.core, pwr.io_reset, pwr.wake_timer_allow});
    cmp("lv ind", 32'h1, lvind);
    pin(3'h2);
    cmp("held low supply", SMPC_STOP1, mode);
    vdd_ok <= 1'b1;
    pin(3'h3);
    cmp("irq ignored", SMPC_STOP1, mode);
    pin(3'h2);
    cmp("stop1 wake", SMPC_RUN, mode);
    cmp("por pulses", 32'h1, n_por);
    rd("ctl2 after por", 8'h04, 32'h0);
  endtask
  task automatic t_stop2;
    enter(8'h07, SMPC_STOP2);
    cmp("stop2 pwr", {SMPC_DOM_OFF, SMPC_DOM_STANDBY, 2'b10},
        {pwr.core, pwr.ram, pwr.io_hold, pwr.periph_clk_en});
    pin(3'h3);
    cmp("stop2 wake", SMPC_RUN, mode);
    cmp("held after wake", 32'h1, pwr.io_hold);
    wr(8'h04, 32'h08);
    cyc(2);
    cmp("released", 32'h0, pwr.io_hold);
  endtask
  task automatic t_stop3;
    for (int i = 0; i < 2; i++) begin
      cpu_up <= i[0];
      xtal <= i[0];
      wte <= i[0];
      enter(8'h04 | (i[7:0] << 1), SMPC_STOP3);
      cmp("stop3 pwr",
          {SMPC_DOM_STANDBY, i[0] ? SMPC_DOM_ACTIVE : SMPC_DOM_OFF, 2'b10, ~i[0], i[0]},
          {pwr.core, pwr.clkgen, pwr.io_hold, pwr.adc_enable, pwr.adc_power_down,
           pwr.wake_timer_allow});
      pin(3'h4);
      cmp("halt ignored", SMPC_STOP3, mode);
      pin(3'h1);
      cmp("stop3 wake", SMPC_RUN, mode);
    end
  endtask
  task automatic t_lvstop;
    wr(8'h00, 32'h0C);
    enter(8'h05, SMPC_STOP3);
    cmp("lv stop pwr", {SMPC_DOM_ACTIVE, SMPC_DOM_STANDBY}, {pwr.regulator, pwr.clkgen});
    pin(3'h3);
    cmp("lv stop wake", SMPC_RUN, mode);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_debug;
    dbg <= 1'b1;
    enter(8'h07, SMPC_STOP3);
    cmp("dbg pwr", {2'b10, SMPC_DOM_ACTIVE, SMPC_DOM_ACTIVE, 1'b0}, {pwr.debug_clk_en,
        pwr.periph_clk_en, pwr.regulator, pwr.clkgen, pwr.wake_timer_1k_ok});
    cmp("in stop", 32'h1, ins);
    pin(3'h5);
    cmp("mem refused", 32'h00010000, {n_err[15:0], n_go[15:0]});
    pin(3'h4);
    cmp("bgnd", 32'h3, {n_bg[30:0], allc});
    cmp("in stop after halt", 32'h0, ins);
    pin(3'h5);
    cmp("mem after halt", 32'h1, n_go);
    dbg <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_illegal();
    t_stop1();
    t_stop2();
    t_stop3();
    t_lvstop();
    t_debug();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule // tb
